// File: include/duo_pkg.sv
// shared constants for the dac update override link and both of its ends
package duo_pkg;
   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 32;
   localparam int BYTE_BITS  = 8;
   localparam int CMD_HI     = 27;
   localparam int CMD_LO     = 24;
   localparam int ADDR_HI    = 23;
   localparam int ADDR_LO    = 20;
   localparam int DATA_HI    = 19;
   localparam int DATA_LO    = 4;
   localparam int CHANNELS   = 4;
   localparam int DATA_W     = 16;

   // ----------------------------------------------------------------
   // command and address codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_WRITE_INPUT  = 4'h0;
   localparam logic [3:0] CMD_WRITE_UPDALL = 4'h2;
   localparam logic [3:0] CMD_CLEAR_CODE   = 4'h5;
   localparam logic [3:0] CMD_OVERRIDE     = 4'h6;
   localparam logic [3:0] ADDR_ALL         = 4'hf;

   // ----------------------------------------------------------------
   // clear codes and values after reset
   // ----------------------------------------------------------------
   localparam logic [1:0]  CLR_ZERO      = 2'h0;
   localparam logic [1:0]  CLR_MID       = 2'h1;
   localparam logic [1:0]  CLR_FULL      = 2'h2;
   localparam logic [15:0] CLR_VAL_ZERO  = 16'h0000;
   localparam logic [15:0] CLR_VAL_MID   = 16'h8000;
   localparam logic [15:0] CLR_VAL_FULL  = 16'hffff;
   localparam logic [3:0]  OVERRIDE_RST  = 4'h0;
   localparam logic [1:0]  CLR_CODE_RST  = 2'h0;
   localparam logic [15:0] DAC_RST       = 16'h0000;

   // ----------------------------------------------------------------
   // host register map (byte addresses) and timing
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_FRAME  = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_PINS   = 4'h8;
   localparam int         CLK_MHZ    = 50;
   localparam int         HALF_NS    = 40;
   localparam int         HALF_CYC   = (HALF_NS * CLK_MHZ) / 1000;
   localparam int         GAP_HALVES = 2;
endpackage

// File: include/duo_link_if.sv
// three-wire serial link plus the load strobe and clear pins
`timescale 1ns/1ps
interface duo_link_if;
   logic sclk;               // link clock, made by the host, idles low
   logic sync_n;             // frame sync, low during a frame
   logic din;                // serial data, msb first
   logic dac_load_strobe_n;  // hardware load strobe
   logic clear_input_n;      // hardware clear, falling edge acts

   modport host
   (
      output sclk,
      output sync_n,
      output din,
      output dac_load_strobe_n,
      output clear_input_n
   );

   modport device
   (
      input sclk,
      input sync_n,
      input din,
      input dac_load_strobe_n,
      input clear_input_n
   );
endinterface

// File: core/duo_dac_dev.sv
// serial command logic of the quad dac: frame capture and update gating
//
// Notes on behaviour
// - cmd 0010: write input, update all dacs
// - cmd 0110 loads db3..db0 into override
// - override bits reset 0; pin governs channel
// - override bit 1: channel updates, pin ignored
// - cmd 0101 takes clear selector from db1..db0
// - chosen channels update, others follow pin
// - host uses clock polarity 0, phase 1
// - host data valid at falling sclk edge
// - host sends msb first
// - sync low across all bytes, raised after last
// - selector 00/01/10 gives 0/8000/ffff, 11 no-op
// - strobe low: update at 32nd falling edge
// - strobe pulsed low copies all inputs to dacs
// - next completed frame ends clear mode; clear aborts write
`timescale 1ns/1ps
module duo_dac_dev
(
   // core clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // link
   duo_link_if.device                link,
   // user side
   output logic [3:0][15:0]          dac_value,
   output logic [3:0][15:0]          input_value,
   output logic [3:0]                update_override_mask,
   output logic [1:0]                clear_code_select,
   output logic                      clear_mode
);
   // ----------------------------------------------------------------
   // link domain: shift register on the falling sclk edge
   // ----------------------------------------------------------------
   logic [30:0] shift;
   logic [5:0]  bit_cnt;
   logic [31:0] frame_word;
   logic        frame_tgl;
   logic        lk_clr_s1;
   logic        lk_clr_s2;
   logic        aborted;

   // data is sampled at the falling edge, msb first
   always_ff @(negedge link.sclk)
   begin
      shift <= {shift[29:0], link.din};
   end

   // sync high ends a frame at once; sclk may stand still outside frames
   always_ff @(negedge link.sclk or posedge link.sync_n or posedge rst)
   begin
      if (rst || link.sync_n)
         bit_cnt <= 6'h00;
      else if (bit_cnt != 6'(duo_pkg::FRAME_BITS))
         bit_cnt <= bit_cnt + 6'h01;
   end

   // clear pin seen in the link domain to abort a running write; sync high
   // empties it, since sclk stops between frames and a stale low would
   // otherwise drop the next frame as well
   always_ff @(negedge link.sclk or posedge link.sync_n or posedge rst)
   begin
      if (rst || link.sync_n)
      begin
         lk_clr_s1 <= 1'b1;
         lk_clr_s2 <= 1'b1;
      end
      else
      begin
         lk_clr_s1 <= link.clear_input_n;
         lk_clr_s2 <= lk_clr_s1;
      end
   end

   // abort flag lives until the frame's own sync rise
   always_ff @(negedge link.sclk or posedge link.sync_n or posedge rst)
   begin
      if (rst || link.sync_n)
         aborted <= 1'b0;
      else if (!lk_clr_s2)
         aborted <= 1'b1;
   end

   // the 32nd falling edge hands a whole word over by a toggle
   always_ff @(negedge link.sclk or posedge rst)
   begin
      if (rst)
      begin
         frame_word <= 32'h0000_0000;
         frame_tgl  <= 1'b0;
      end
      else if (bit_cnt == 6'(duo_pkg::FRAME_BITS - 1) && !aborted
               && lk_clr_s2)
      begin
         frame_word <= {shift, link.din};
         frame_tgl  <= ~frame_tgl;
      end
   end

   // ----------------------------------------------------------------
   // core domain: crossings
   // ----------------------------------------------------------------
   logic [2:0] tgl_sync;
   logic [2:0] load_sync;
   logic [2:0] clr_sync;
   logic       frame_done;
   logic       load_fall;
   logic       clr_fall;

   // word stays still for many core cycles after the toggle moves
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         tgl_sync  <= 3'h0;
         load_sync <= 3'h7;
         clr_sync  <= 3'h7;
      end
      else
      begin
         tgl_sync  <= {tgl_sync[1:0], frame_tgl};
         load_sync <= {load_sync[1:0], link.dac_load_strobe_n};
         clr_sync  <= {clr_sync[1:0], link.clear_input_n};
      end
   end

   assign frame_done = tgl_sync[2] ^ tgl_sync[1];
   assign load_fall  = load_sync[2] & ~load_sync[1];
   assign clr_fall   = clr_sync[2] & ~clr_sync[1];

   // ----------------------------------------------------------------
   // core domain: frame decode
   // ----------------------------------------------------------------
   logic [3:0]  cmd;
   logic [3:0]  addr;
   logic [15:0] data;
   logic        is_write;
   logic        is_updall;
   logic [3:0]  chan_hit;
   logic [15:0] clr_val;
   logic        clr_act;

   assign cmd  = frame_word[duo_pkg::CMD_HI:duo_pkg::CMD_LO];
   assign addr = frame_word[duo_pkg::ADDR_HI:duo_pkg::ADDR_LO];
   assign data = frame_word[duo_pkg::DATA_HI:duo_pkg::DATA_LO];
   assign is_updall = frame_done && cmd == duo_pkg::CMD_WRITE_UPDALL;
   assign is_write  = frame_done &&
                      (cmd == duo_pkg::CMD_WRITE_INPUT || is_updall);

   // clear value chosen by the stored selector
   always_comb
   begin
      clr_act = 1'b1;
      case (clear_code_select)
         duo_pkg::CLR_ZERO: clr_val = duo_pkg::CLR_VAL_ZERO;
         duo_pkg::CLR_MID:  clr_val = duo_pkg::CLR_VAL_MID;
         duo_pkg::CLR_FULL: clr_val = duo_pkg::CLR_VAL_FULL;
         default:
         begin
            clr_val = duo_pkg::CLR_VAL_ZERO;
            clr_act = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // per-channel input and dac registers
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < duo_pkg::CHANNELS; ch++)
      begin : g_chan
         logic [15:0] next_input;
         logic        sync_upd;

         assign chan_hit[ch] = is_write &&
                               (addr == 4'(ch) || addr == duo_pkg::ADDR_ALL);
         assign next_input = chan_hit[ch] ? data : input_value[ch];
         // an override bit makes the channel see the strobe as low
         assign sync_upd = is_write &&
                           (update_override_mask[ch] || !load_sync[2]);

         always_ff @(posedge core_clk)
         begin
            if (rst)
               input_value[ch] <= duo_pkg::DAC_RST;
            else if (clr_fall && clr_act)
               input_value[ch] <= clr_val;
            else
               input_value[ch] <= next_input;
         end

         // clear beats a write, a write beats a strobe pulse
         always_ff @(posedge core_clk)
         begin
            if (rst)
               dac_value[ch] <= duo_pkg::DAC_RST;
            else if (clr_fall && clr_act)
               dac_value[ch] <= clr_val;
            else if (is_updall)
               dac_value[ch] <= next_input;
            else if (sync_upd)
               dac_value[ch] <= next_input;
            else if (load_fall)
               dac_value[ch] <= input_value[ch];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // override mask changes only how later updates are gated
   always_ff @(posedge core_clk)
   begin
      if (rst)
         update_override_mask <= duo_pkg::OVERRIDE_RST;
      else if (frame_done && cmd == duo_pkg::CMD_OVERRIDE)
         update_override_mask <= frame_word[3:0];
   end

   // clear selector, bits 1 and 0 of its frame
   always_ff @(posedge core_clk)
   begin
      if (rst)
         clear_code_select <= duo_pkg::CLR_CODE_RST;
      else if (frame_done && cmd == duo_pkg::CMD_CLEAR_CODE)
         clear_code_select <= frame_word[1:0];
   end

   // clear mode entered by the pin unless the selector is 11, left by the next completed frame of any command
   always_ff @(posedge core_clk)
   begin
      if (rst)
         clear_mode <= 1'b0;
      else if (clr_fall && clr_act)
         clear_mode <= 1'b1;
      else if (frame_done)
         clear_mode <= 1'b0;
   end
endmodule // duo_dac_dev

// File: core/duo_host.sv
// host end: avalon-mm slave that sends frames over the serial link
`timescale 1ns/1ps
module duo_host
#(
   parameter int HALF_CYC   = duo_pkg::HALF_CYC,
   parameter int GAP_HALVES = duo_pkg::GAP_HALVES
)
(
   // core clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // link
   duo_link_if.host         link
);
   typedef enum logic [4:0]
   {
      ST_IDLE  = 5'h01,
      ST_LEAD  = 5'h02,
      ST_SHIFT = 5'h04,
      ST_GAP   = 5'h08,
      ST_TAIL  = 5'h10
   } duo_hst_t;

   duo_hst_t    state;
   logic [7:0]  div_cnt;
   logic        tick;
   logic [31:0] word;
   logic [4:0]  bits_sent;
   logic [3:0]  gap_cnt;
   logic        start;
   logic        sclk_q;
   logic        sync_q;
   logic        din_q;
   logic        load_q;
   logic        clr_q;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   // a frame starts at the edge at which the master sees the answer
   assign start = write && !waitrequest && address == duo_pkg::REG_FRAME;

   // answer is one cycle late so waitrequest comes from a flop; a write
   // lands only at the edge where the master samples waitrequest low
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
         load_q      <= 1'b1;
         clr_q       <= 1'b1;
      end
      else if (!waitrequest)
      begin
         waitrequest <= 1'b1;
         if (write && address == duo_pkg::REG_PINS)
         begin
            load_q <= writedata[0];
            clr_q  <= writedata[1];
         end
      end
      else if (!(read || write))
         waitrequest <= 1'b1;
      else if (read)
      begin
         case (address)
            duo_pkg::REG_STATUS:
               readdata <= {31'h0, state != ST_IDLE};
            duo_pkg::REG_PINS:
               readdata <= {30'h0, clr_q, load_q};
            default:
               readdata <= 32'h0000_0000;
         endcase
         waitrequest <= 1'b0;
      end
      else if (address != duo_pkg::REG_FRAME || state == ST_IDLE)
         waitrequest <= 1'b0;    // a frame write waits for the sequencer
   end

   // ----------------------------------------------------------------
   // link clock divider, counts only while a frame runs
   // ----------------------------------------------------------------
   assign tick = div_cnt == 8'(HALF_CYC - 1);

   always_ff @(posedge core_clk)
   begin
      if (rst || state == ST_IDLE || tick)
         div_cnt <= 8'h00;
      else
         div_cnt <= div_cnt + 8'h01;
   end

   // ----------------------------------------------------------------
   // frame sequencer: data moves on the rise, held over the fall
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state     <= ST_IDLE;
         sclk_q    <= 1'b0;
         sync_q    <= 1'b1;
         din_q     <= 1'b0;
         word      <= 32'h0000_0000;
         bits_sent <= 5'h00;
         gap_cnt   <= 4'h0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (start)
               begin
                  word      <= writedata;
                  sync_q    <= 1'b0;
                  bits_sent <= 5'h00;
                  state     <= ST_LEAD;
               end
            ST_LEAD:
               if (tick)
                  state <= ST_SHIFT;
            ST_SHIFT:
               if (tick)
               begin
                  sclk_q <= ~sclk_q;
                  if (!sclk_q)
                  begin
                     din_q <= word[31];
                     word  <= {word[30:0], 1'b0};
                  end
                  else
                  begin
                     bits_sent <= bits_sent + 5'h01;
                     gap_cnt   <= 4'h0;
                     if (bits_sent == 5'(duo_pkg::FRAME_BITS - 1))
                        state <= ST_TAIL;
                     else if (bits_sent[2:0] == 3'(duo_pkg::BYTE_BITS - 1))
                        state <= ST_GAP;
                  end
               end
            ST_GAP:
               if (tick)
               begin
                  gap_cnt <= gap_cnt + 4'h1;
                  if (gap_cnt == 4'(GAP_HALVES - 1))
                     state <= ST_SHIFT;
               end
            ST_TAIL:
               if (tick)
               begin
                  sync_q <= 1'b1;
                  state  <= ST_IDLE;
               end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   assign link.sclk              = sclk_q;
   assign link.sync_n            = sync_q;
   assign link.din               = din_q;
   assign link.dac_load_strobe_n = load_q;
   assign link.clear_input_n     = clr_q;
endmodule // duo_host

// File: tb/duo_monitor.sv
// concurrent checks on the serial link between host and dac ends
`timescale 1ns/1ps
module duo_monitor
(
   // core clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link wires
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire logic dac_load_strobe_n,
   input wire logic clear_input_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // helper: falling link clock edges counted within one frame
   // ---------------------------------------------------------------
   logic       prev_sclk;
   logic [5:0] nfall;

   // cleared while sync is high so a dropped frame cannot leak counts
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         prev_sclk <= 1'b0;
         nfall     <= 6'h00;
      end
      else
      begin
         prev_sclk <= sclk;
         if (sync_n)
            nfall <= 6'h00;
         else if (prev_sclk && !sclk)
            nfall <= nfall + 6'h01;
      end
   end

   // ---------------------------------------------------------------
   // wire rules
   // ---------------------------------------------------------------
   a_sclk_idle_low: assert property (sync_n |-> !sclk)
      else $error("link clock high outside a frame");
   a_sclk_high_half: assert property ($rose(sclk) |-> ##1 sclk ##1 !sclk)
      else $error("link clock high phase not two cycles");
   a_din_stable_fall: assert property ($fell(sclk) |-> $stable(din))
      else $error("data moved at the sampling edge");
   a_sync_setup: assert property ($fell(sync_n) |-> !sclk ##1 !sclk)
      else $error("frame sync without setup before first clock");
   a_sync_tail: assert property ($rose(sync_n) |-> $past(sclk) == 1'b0)
      else $error("frame sync raised too close to last edge");
   a_frame_bits: assert property ($rose(sync_n) |-> nfall == 6'd32)
      else $error("frame not thirty two bits");
   a_frame_max: assert property (!sync_n |-> nfall <= 6'd32)
      else $error("frame longer than thirty two bits");
   a_byte_gap: assert property
      ($fell(sclk) && nfall inside {6'd7, 6'd15, 6'd23} |-> !sclk[*4])
      else $error("no gap between bytes");

   // ---------------------------------------------------------------
   // pin pulses must outlast the two-flop synchronisers
   // ---------------------------------------------------------------
   a_clear_wide: assert property
      ($fell(clear_input_n) |-> !clear_input_n[*3])
      else $error("clear pulse too short to be seen");
   a_strobe_wide: assert property
      ($fell(dac_load_strobe_n) |-> !dac_load_strobe_n[*3])
      else $error("load strobe pulse too short to be seen");
endmodule // duo_monitor

// File: tb/tb_top.sv
// self-checking bench: avalon host end driving the dac end
`timescale 1ns/1ps
module tb_top;
   logic             core_clk;
   logic             rst;
   logic [3:0]       address;
   logic             read;
   logic             write;
   logic [31:0]      writedata;
   logic [31:0]      readdata;
   logic             waitrequest;
   logic [3:0][15:0] dac_value;
   logic [3:0][15:0] input_value;
   logic [3:0]       update_override_mask;
   logic [1:0]       clear_code_select;
   logic             clear_mode;
   logic [31:0]      rd;
   logic [15:0]      exp_in;
   logic [15:0]      exp_dac;
   logic [15:0]      cval [3] = '{duo_pkg::CLR_VAL_ZERO,
                                  duo_pkg::CLR_VAL_MID,
                                  duo_pkg::CLR_VAL_FULL};
   int               num_errors = 0;
   int               n_tests = 0;
   int               cycles = 0;

   // ---------------------------------------------------------------
   // both ends and the link watcher
   // ---------------------------------------------------------------
   duo_link_if duo_link_if_inst();
   duo_host duo_host_inst(.core_clk, .rst, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .link(duo_link_if_inst.host));
   duo_dac_dev duo_dac_dev_inst(.core_clk, .rst,
      .link(duo_link_if_inst.device), .dac_value, .input_value,
      .update_override_mask, .clear_code_select, .clear_mode);
   duo_monitor duo_monitor_inst(.core_clk, .rst,
      .sclk(duo_link_if_inst.sclk), .sync_n(duo_link_if_inst.sync_n),
      .din(duo_link_if_inst.din),
      .dac_load_strobe_n(duo_link_if_inst.dac_load_strobe_n),
      .clear_input_n(duo_link_if_inst.clear_input_n));

   // 50 MHz core clock
   always #10 core_clk = ~core_clk;

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // one avalon transfer; held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= !wr;
      do
         @(posedge core_clk);
      while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   // poll busy, then leave room for the crossed frame to be decoded
   task automatic settle();
      do
         bus(1'b0, duo_pkg::REG_STATUS, 32'h0);
      while (rd[0] !== 1'b0);
      repeat (8) @(posedge core_clk);
   endtask

   task automatic frame(input logic [31:0] w);
      bus(1'b1, duo_pkg::REG_FRAME, w);
      settle();
   endtask

   // pin levels: bit0 load strobe, bit1 clear
   task automatic pins(input logic strobe, input logic clr);
      bus(1'b1, duo_pkg::REG_PINS, {30'h0, clr, strobe});
      repeat (6) @(posedge core_clk);
   endtask

   function automatic logic [31:0] word(input logic [3:0] cmd,
      input logic [3:0] adr, input logic [15:0] dat);
      return {4'h0, cmd, adr, dat, 4'h0};
   endfunction

   // a hang counts as a mismatch and closes the run
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      core_clk  = 1'b0;
      rst       = 1'b1;
      address   = 4'h0;
      read      = 1'b0;
      write     = 1'b0;
      writedata = 32'h0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      check(update_override_mask, duo_pkg::OVERRIDE_RST);
      bus(1'b0, duo_pkg::REG_PINS, 32'h0);
      check(rd, 32'h3);
      bus(1'b0, 4'hc, 32'hffff_ffff);
      check(rd, 32'h0);
      $display("reset test done");
      // strobe high: input only, then a pulse copies it across
      frame(word(duo_pkg::CMD_WRITE_INPUT, 4'h1, 16'h1234));
      check(input_value[1], 16'h1234);
      check(dac_value[1], duo_pkg::DAC_RST);
      pins(1'b0, 1'b1);
      pins(1'b1, 1'b1);
      check(dac_value[1], 16'h1234);
      $display("strobe test done");
      // override load with every don't-care bit set
      frame(32'hf6ff_fff5);
      check(update_override_mask, 4'h5);
      check(input_value[1], 16'h1234);
      check(dac_value[1], 16'h1234);
      frame(word(duo_pkg::CMD_WRITE_INPUT, 4'h0, 16'haaaa));
      check(dac_value[0], 16'haaaa);
      frame(word(duo_pkg::CMD_WRITE_INPUT, 4'h1, 16'hbbbb));
      check(dac_value[1], 16'h1234);
      frame(word(duo_pkg::CMD_WRITE_UPDALL, 4'h3, 16'hcccc));
      check(dac_value[3], 16'hcccc);
      check(dac_value[1], 16'hbbbb);
      $display("override test done");
      // strobe held low: update at the end of the frame
      frame(32'hf6ff_fff0);
      check(update_override_mask, 4'h0);
      pins(1'b0, 1'b1);
      frame(word(duo_pkg::CMD_WRITE_INPUT, 4'h2, 16'h5678));
      check(dac_value[2], 16'h5678);
      pins(1'b1, 1'b1);
      $display("sync update test done");
      // every clear code, junk in the ignored fields
      for (int c = 0; c < 4; c++)
      begin
         frame({4'ha, duo_pkg::CMD_CLEAR_CODE, 4'h9, 16'h5a5a, 2'h3,
                c[1:0]});
         check(clear_code_select, c[1:0]);
         frame(word(duo_pkg::CMD_WRITE_INPUT, 4'h0, 16'h0001));
         pins(1'b1, 1'b0);
         pins(1'b1, 1'b1);
         exp_in  = (c < 3) ? cval[c] : 16'h0001;
         exp_dac = (c < 3) ? cval[c] : duo_pkg::CLR_VAL_FULL;
         check(input_value[0], exp_in);
         check(dac_value[0], exp_dac);
         if (c < 3)
            check(clear_mode, 1'b1);
         frame(word(duo_pkg::CMD_WRITE_INPUT, 4'h1, 16'h0002));
         check(clear_mode, 1'b0);
      end
      $display("clear code test done");
      // clear in mid-frame drops the write (code 11 keeps values)
      bus(1'b1, duo_pkg::REG_FRAME,
          word(duo_pkg::CMD_WRITE_INPUT, 4'h2, 16'h9999));
      repeat (40) @(posedge core_clk);
      pins(1'b1, 1'b0);
      settle();
      pins(1'b1, 1'b1);
      check(input_value[2], duo_pkg::CLR_VAL_FULL);
      // the write after an abort lands, here on every channel at once
      frame(word(duo_pkg::CMD_WRITE_INPUT, duo_pkg::ADDR_ALL, 16'h4321));
      check(input_value[2], 16'h4321);
      check(input_value[0], 16'h4321);
      $display("abort test done");
      print_verdict();
   end
endmodule // tb_top
